// file: hdl/spw_channel.sv
// One waveform channel: level state and registered output pin
`timescale 1ns/1ps
`default_nettype none
module spw_channel (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic active,
    input  wire logic match,
    input  wire logic atZero,
    input  wire logic defaultLevel,
    input  wire logic polarityFlip,
    output var  logic waveformOutPin
);
    import spw_pkg::*;

    logic level;
    logic next_level;

    // ****************************************
    // Level decision
    // ****************************************
    // Match wins over zero so a compare of 0000h gives a full-high period
    assign next_level = !active ? defaultLevel :
                        match   ? 1'b1 :
                        atZero  ? 1'b0 :
                                  level;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            level          <= 1'b0;
            waveformOutPin <= 1'b0;
        end else begin
            level          <= next_level;
            waveformOutPin <= next_level ^ polarityFlip;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_match_sets_high: assert property (active && match |=> level)
        else $error("Match did not raise level");
    a_zero_sets_low: assert property (active && atZero && !match |=> !level)
        else $error("Zero did not lower level");
    a_idle_default: assert property (!active ##1 !active |-> level == $past(defaultLevel))
        else $error("Idle level differs from default");
    a_pin_polarity: assert property (##1 waveformOutPin == (level ^ $past(polarityFlip)))
        else $error("Pin polarity wrong");

endmodule // spw_channel
`default_nettype wire

// file: hdl/spw_pkg.sv
// Constants for the single-phase waveform output block
// Overview of operation
// - Pin goes high on compare match
// - Pin returns low at timer zero
// - Default level bit sets starting level
// - Polarity flip bit inverts the output
// - Free-running period is 65536 counts
// - Channel-0 reset mode period is n+2
// - Reset mode: channels 1-7 only generate
// - Compare at least n+2 stays low
// - Enable bit set starts output
// - Enable bit cleared stops output
// - Every match on an enabled channel sets request flag
// - Kind field chooses mode, port bit overrides
package spw_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_CH    = 8;
    localparam int ADDR_W    = 5;
    localparam int DATA_W    = 16;
    localparam int TIMER_W   = 16;

    // ****************************************
    // Register map, word addresses
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_BASE_TIMER_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_FUNC_ENABLE     = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_FUNC_SELECT     = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_MATCH_REQUEST   = 5'h03;
    localparam logic [ADDR_W-1:0] ADDR_TIMER_VALUE     = 5'h04;
    localparam logic [1:0]        PAGE_OUTPUT_CTRL     = 2'h1;
    localparam logic [1:0]        PAGE_COMPARE         = 2'h2;

    // ****************************************
    // Field layouts
    // ****************************************
    localparam int RSTSEL_LSB = 0;
    localparam int RSTSEL_MSB = 2;
    localparam int TIMER_RUN_BIT = 3;
    localparam int KIND_LSB   = 0;
    localparam int KIND_MSB   = 2;
    localparam int DEFLVL_BIT = 3;
    localparam int INVERT_BIT = 4;
    localparam int RTPORT_BIT = 5;
    localparam int OCR_W      = 6;
    localparam int PAGE_MSB   = 4;
    localparam int PAGE_LSB   = 3;
    localparam int INDEX_MSB  = 2;
    localparam int CTRL_USED_W = 4;

    // ****************************************
    // Encodings and reset values
    // ****************************************
    localparam logic [2:0] RSTSEL_FREE_RUN   = 3'h0;
    localparam logic [2:0] RSTSEL_ON_CH0     = 3'h2;
    localparam logic [2:0] KIND_SINGLE_PHASE = 3'h0;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
    localparam logic [TIMER_W-1:0] TIMER_MAX  = 16'hffff;
    localparam logic [TIMER_W-1:0] TIMER_STEP = 16'h0001;
    localparam logic [DATA_W-1:0]  DATA_ZERO  = 16'h0000;
    localparam logic [OCR_W-1:0]   OCR_RESET  = 6'h00;
    localparam logic [NUM_CH-1:0]  CH_NONE    = 8'h00;

endpackage

// file: hdl/spw_top.sv
// Single-phase waveform output block: base timer, registers, channels
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module spw_top (
    input  wire logic                         clk_sys,
    input  wire logic                         srst,
    input  wire logic [spw_pkg::ADDR_W-1:0]   regAddr,
    input  wire logic [spw_pkg::DATA_W-1:0]   regWrData,
    input  wire logic                         regWrStb,
    input  wire logic                         regRdStb,
    output var  logic [spw_pkg::DATA_W-1:0]   regRdData,
    output var  logic [spw_pkg::NUM_CH-1:0]   waveformOutPin,
    output var  logic [spw_pkg::NUM_CH-1:0]   compareMatchRequest
);
    import spw_pkg::*;

    // ****************************************
    // Storage
    // ****************************************
    logic [2:0]         timerResetSelect;
    logic               timerRun;
    logic [NUM_CH-1:0]  channelEnable;
    logic [NUM_CH-1:0]  functionSelect;
    logic [TIMER_W-1:0] timerValue;
    logic               resetPending;
    logic [DATA_W-1:0]  compareValue [NUM_CH];
    logic [OCR_W-1:0]   outputControl [NUM_CH];

    function automatic logic fnIsMatch(input logic [TIMER_W-1:0] t,
                                       input logic [DATA_W-1:0] c);
        return t == c;
    endfunction

    // ****************************************
    // Decode
    // ****************************************
    wire               wrCtrl    = regWrStb && regAddr == ADDR_BASE_TIMER_CTRL;
    wire               wrEnable  = regWrStb && regAddr == ADDR_FUNC_ENABLE;
    wire               wrSelect  = regWrStb && regAddr == ADDR_FUNC_SELECT;
    wire               wrRequest = regWrStb && regAddr == ADDR_MATCH_REQUEST;
    wire               wrOcr     = regWrStb && regAddr[PAGE_MSB:PAGE_LSB] == PAGE_OUTPUT_CTRL;
    wire               wrCmp     = regWrStb && regAddr[PAGE_MSB:PAGE_LSB] == PAGE_COMPARE;
    wire [INDEX_MSB:0] regIndex  = regAddr[INDEX_MSB:0];
    wire               resetMode = timerResetSelect == RSTSEL_ON_CH0;
    wire               atZero    = timerValue == TIMER_ZERO;
    wire [NUM_CH-1:0]  matchVec;
    wire [NUM_CH-1:0]  chanActive;
    wire [NUM_CH-1:0]  requestSet;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            wire [OCR_W-1:0] ocr = outputControl[g];
            wire waveKindOk = !ocr[RTPORT_BIT]
                           && ocr[KIND_MSB:KIND_LSB] == KIND_SINGLE_PHASE;
            // Channel 0 only sets the period in reset mode
            wire periodOnly = resetMode && (g == 0);
            assign matchVec[g]   = timerRun && fnIsMatch(timerValue, compareValue[g]);
            // Select bit high means time measurement owns the channel
            assign chanActive[g] = channelEnable[g] && !functionSelect[g]
                                && waveKindOk && !periodOnly;
            assign requestSet[g] = channelEnable[g] && matchVec[g];

            spw_channel u_channel (
                .clk_sys        (clk_sys),
                .srst           (srst),
                .active         (chanActive[g]),
                .match          (matchVec[g]),
                .atZero         (timerRun && atZero),
                .defaultLevel   (ocr[DEFLVL_BIT]),
                .polarityFlip   (ocr[INVERT_BIT]),
                .waveformOutPin (waveformOutPin[g])
            );
        end
    endgenerate

    // ****************************************
    // Base timer
    // ****************************************
    // Reset lands one count after the channel-0 match, so the period is n+2
    wire [TIMER_W-1:0] next_timerValue =
        !timerRun    ? timerValue :
        resetPending ? TIMER_ZERO :
                       timerValue + TIMER_STEP;
    wire next_resetPending = timerRun ? (resetMode && matchVec[0]) : resetPending;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            timerValue   <= TIMER_ZERO;
            resetPending <= 1'b0;
        end else begin
            timerValue   <= next_timerValue;
            resetPending <= next_resetPending;
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            timerResetSelect <= RSTSEL_FREE_RUN;
            timerRun         <= 1'b0;
            channelEnable    <= CH_NONE;
            functionSelect   <= CH_NONE;
        end else begin
            if (wrCtrl) begin
                timerResetSelect <= regWrData[RSTSEL_MSB:RSTSEL_LSB];
                timerRun         <= regWrData[TIMER_RUN_BIT];
            end
            if (wrEnable) begin
                channelEnable <= regWrData[NUM_CH-1:0];
            end
            if (wrSelect) begin
                functionSelect <= regWrData[NUM_CH-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                compareValue[i]  <= DATA_ZERO;
                outputControl[i] <= OCR_RESET;
            end
        end else begin
            if (wrCmp) begin
                compareValue[regIndex] <= regWrData;
            end
            if (wrOcr) begin
                outputControl[regIndex] <= regWrData[OCR_W-1:0];
            end
        end
    end

    // Write one to clear; a match in the same cycle keeps the flag set
    wire [NUM_CH-1:0] clearMask = wrRequest ? regWrData[NUM_CH-1:0] : CH_NONE;
    wire [NUM_CH-1:0] next_request = (compareMatchRequest & ~clearMask) | requestSet;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            compareMatchRequest <= CH_NONE;
        end else begin
            compareMatchRequest <= next_request;
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    wire [DATA_W-1:0] readCtrl = {{(DATA_W-CTRL_USED_W){1'b0}}, timerRun, timerResetSelect};
    wire [DATA_W-1:0] readMux =
        regAddr == ADDR_BASE_TIMER_CTRL ? readCtrl :
        regAddr == ADDR_FUNC_ENABLE     ? {{(DATA_W-NUM_CH){1'b0}}, channelEnable} :
        regAddr == ADDR_FUNC_SELECT     ? {{(DATA_W-NUM_CH){1'b0}}, functionSelect} :
        regAddr == ADDR_MATCH_REQUEST   ? {{(DATA_W-NUM_CH){1'b0}}, compareMatchRequest} :
        regAddr == ADDR_TIMER_VALUE     ? timerValue :
        regAddr[PAGE_MSB:PAGE_LSB] == PAGE_OUTPUT_CTRL ?
            {{(DATA_W-OCR_W){1'b0}}, outputControl[regIndex]} :
        regAddr[PAGE_MSB:PAGE_LSB] == PAGE_COMPARE ? compareValue[regIndex] :
                                          DATA_ZERO;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            regRdData <= DATA_ZERO;
        end else begin
            regRdData <= regRdStb ? readMux : DATA_ZERO;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_free_wrap: assert property (timerRun && !resetMode && !resetPending
        && timerValue == TIMER_MAX |=> timerValue == TIMER_ZERO)
        else $error("Free-running timer failed to wrap");
    a_ch0_reset: assert property (timerRun && resetMode && matchVec[0]
        ##1 timerRun |-> timerValue == $past(timerValue) + TIMER_STEP ##1 timerValue == TIMER_ZERO)
        else $error("Channel-0 reset sequence wrong");
    a_ch0_period_only: assert property (resetMode |-> !chanActive[0])
        else $error("Channel 0 generating in reset mode");
    a_request_set: assert property (channelEnable[0] && matchVec[0]
        |=> compareMatchRequest[0])
        else $error("Match did not set request flag");
    a_request_clear: assert property (wrRequest && regWrData[1] && !requestSet[1]
        |=> !compareMatchRequest[1])
        else $error("Request flag not cleared");
    a_disable_stops: assert property (wrEnable && !regWrData[2] |=> !chanActive[2])
        else $error("Cleared enable still active");

endmodule // spw_top
`default_nettype wire

// file: tb/spw_load_model.sv
// Load on the waveform pins: measures run widths and rising edges
`timescale 1ns/1ps
`default_nettype none
module spw_load_model (
    input  wire logic                             clk_sys,
    input  wire logic                             srst,
    input  wire logic [spw_pkg::NUM_CH-1:0]       waveformOutPin,
    output var  logic [spw_pkg::NUM_CH-1:0][31:0] highWidth,
    output var  logic [spw_pkg::NUM_CH-1:0][31:0] lowWidth,
    output var  logic [spw_pkg::NUM_CH-1:0][31:0] riseCount
);
    import spw_pkg::*;

    logic [NUM_CH-1:0][31:0] runLen;
    logic [NUM_CH-1:0]       lastLevel;

    // ****************************************
    // Width capture
    // ****************************************
    // Only completed runs are reported, but the partial first run, counted from reset, shows once it ends
    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (srst) begin
                runLen[c]    <= 32'h1;
                lastLevel[c] <= 1'b0;
                highWidth[c] <= 32'h0;
                lowWidth[c]  <= 32'h0;
                riseCount[c] <= 32'h0;
            end else if (waveformOutPin[c] != lastLevel[c]) begin
                if (lastLevel[c]) highWidth[c] <= runLen[c];
                else lowWidth[c] <= runLen[c];
                if (waveformOutPin[c]) riseCount[c] <= riseCount[c] + 32'h1;
                runLen[c]    <= 32'h1;
                lastLevel[c] <= waveformOutPin[c];
            end else begin
                runLen[c] <= runLen[c] + 32'h1;
            end
        end
    end
endmodule // spw_load_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the single-phase waveform output block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spw_pkg::*;

    logic                     clk_sys;
    logic                     srst;
    logic [ADDR_W-1:0]        regAddr;
    logic [DATA_W-1:0]        regWrData;
    logic                     regWrStb;
    logic                     regRdStb;
    logic [DATA_W-1:0]        regRdData;
    logic [NUM_CH-1:0]        waveformOutPin;
    logic [NUM_CH-1:0]        compareMatchRequest;
    logic [NUM_CH-1:0][31:0]  highWidth;
    logic [NUM_CH-1:0][31:0]  lowWidth;
    logic [NUM_CH-1:0][31:0]  riseCount;
    logic [DATA_W-1:0]        rdVal;
    logic [31:0]              riseSnap;
    int                       fails;
    int                       cmp_count;

    spw_top spw_top_i (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .waveformOutPin(waveformOutPin),
        .compareMatchRequest(compareMatchRequest));
    spw_load_model spw_load_model_i (.clk_sys(clk_sys), .srst(srst),
        .waveformOutPin(waveformOutPin), .highWidth(highWidth),
        .lowWidth(lowWidth), .riseCount(riseCount));

    // ****************************************
    // Bus tasks and compare
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge clk_sys);
        regWrStb  <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clk_sys);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge clk_sys);
        regRdStb <= 1'b0;
        #1;
        rdVal = regRdData;
    endtask

    task automatic print_verdict();
        if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Whole run is about 66000 cycles
    initial begin
        repeat (90000) @(posedge clk_sys);
        fails++;
        print_verdict();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        fails = 0;
        cmp_count = 0;
        srst = 1'b1;
        regAddr = '0;
        regWrData = '0;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        // Timer set up first, all channels on waveforms
        wr(ADDR_BASE_TIMER_CTRL, 16'(RSTSEL_ON_CH0));
        wr(ADDR_FUNC_SELECT, 16'h0000);
        wr({PAGE_COMPARE, 3'h0}, 16'h000a);
        wr({PAGE_COMPARE, 3'h1}, 16'h0004);
        wr({PAGE_COMPARE, 3'h2}, 16'h000c);
        wr({PAGE_COMPARE, 3'h3}, 16'h0003);
        wr({PAGE_COMPARE, 3'h4}, 16'h0005);
        wr({PAGE_COMPARE, 3'h5}, 16'h0004);
        wr({PAGE_COMPARE, 3'h6}, 16'h0004);
        wr({PAGE_OUTPUT_CTRL, 3'h3}, 16'h0010);
        wr({PAGE_OUTPUT_CTRL, 3'h4}, 16'h0008);
        wr({PAGE_OUTPUT_CTRL, 3'h5}, 16'h0001);
        wr({PAGE_OUTPUT_CTRL, 3'h6}, 16'h0020);
        wr(ADDR_FUNC_ENABLE, 16'h007f);
        repeat (2) @(posedge clk_sys);
        chk("start levels", 32'hc, 32'(waveformOutPin[4:1]));
        wr(ADDR_BASE_TIMER_CTRL, 16'(RSTSEL_ON_CH0) | (16'h0001 << TIMER_RUN_BIT));
        repeat (60) @(posedge clk_sys);
        chk("ch1 low", 32'd4, lowWidth[1]);
        chk("ch1 high", 32'd8, highWidth[1]);
        chk("ch3 high", 32'd3, highWidth[3]);
        chk("ch3 low", 32'd9, lowWidth[3]);
        chk("ch4 high", 32'd7, highWidth[4]);
        chk("ch2 rises", 32'd0, riseCount[2]);
        chk("ch2 pin", 32'd0, 32'(waveformOutPin[2]));
        chk("ch0 rises", 32'd0, riseCount[0]);
        chk("ch5 ch6 rises", 32'd0, riseCount[5] | riseCount[6]);
        chk("flags", 32'h1b, 32'(compareMatchRequest[4:0]));
        rd(ADDR_MATCH_REQUEST);
        chk("flag reg", 32'h1b, 32'(rdVal[4:0]));
        wr(ADDR_FUNC_ENABLE, 16'h007d);
        // A rise launched by the last match is counted one edge late
        repeat (2) @(posedge clk_sys);
        riseSnap = riseCount[1];
        repeat (30) @(posedge clk_sys);
        chk("ch1 stopped pin", 32'd0, 32'(waveformOutPin[1]));
        chk("ch1 stopped rises", riseSnap, riseCount[1]);
        wr(ADDR_MATCH_REQUEST, 16'h0002);
        rd(ADDR_MATCH_REQUEST);
        chk("flag clear", 32'h19, 32'(rdVal[4:0]));
        rd({PAGE_COMPARE, 3'h1});
        chk("compare readback", 32'h4, 32'(rdVal));
        @(posedge clk_sys);
        #1;
        chk("read data idle", 32'h0, 32'(regRdData));
        rd(5'h1f);
        chk("unmapped read", 32'h0, 32'(rdVal));
        // Second reset mid-run, then a full free-running period
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        rd(ADDR_MATCH_REQUEST);
        chk("flags after reset", 32'h0, 32'(rdVal));
        wr(ADDR_BASE_TIMER_CTRL, 16'(RSTSEL_FREE_RUN));
        wr({PAGE_COMPARE, 3'h1}, 16'h0004);
        wr(ADDR_FUNC_ENABLE, 16'h0002);
        wr(ADDR_BASE_TIMER_CTRL, 16'(RSTSEL_FREE_RUN) | (16'h0001 << TIMER_RUN_BIT));
        repeat (65560) @(posedge clk_sys);
        chk("free high", 32'd65532, highWidth[1]);
        chk("free low", 32'd4, lowWidth[1]);
        // Timer ran 65562 counts before the stop lands, so it wrapped once
        wr(ADDR_BASE_TIMER_CTRL, 16'(RSTSEL_ON_CH0));
        rd(ADDR_TIMER_VALUE);
        chk("timer value", 32'h1a, 32'(rdVal));
        rd(ADDR_BASE_TIMER_CTRL);
        chk("ctrl readback", 32'h2, 32'(rdVal));
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
